// ---- pkg/wdog_pkg.sv ----
// constants for the configuration-port watchdog
package wdog_pkg;
    localparam logic [7:0]  INDEX_PORT      = 8'h2E;
    localparam logic [7:0]  DATA_PORT       = 8'h2F;
    localparam logic [7:0]  UNLOCK_VALUE    = 8'h87;
    localparam logic [7:0]  LOCK_VALUE      = 8'hAA;
    localparam logic [7:0]  OFS_DEV_SELECT  = 8'h07;
    localparam logic [7:0]  OFS_ACTIVATE    = 8'h30;
    localparam logic [7:0]  OFS_TIME_BASE   = 8'hF5;
    localparam logic [7:0]  OFS_COUNT_VALUE = 8'hF6;
    localparam logic [7:0]  WDOG_DEVICE     = 8'h08;
    localparam logic [7:0]  BASE_SECONDS    = 8'h00;
    localparam logic [7:0]  BASE_MINUTES    = 8'h08;
    localparam logic [7:0]  RST_DEV_SELECT  = 8'h00;
    localparam logic [7:0]  RST_ACTIVATE    = 8'h00;
    localparam logic [7:0]  RST_TIME_BASE   = 8'h00;
    localparam logic [7:0]  RST_COUNT_VALUE = 8'h00;
    localparam int          CLOCK_HZ        = 20000000;
    localparam int          SECOND_S        = 1;
    localparam int          SECOND_CYCLES   = CLOCK_HZ * SECOND_S;
    localparam int          MINUTE_SECONDS  = 60;
    localparam int          RESET_PULSE_US  = 100;
    localparam int          RESET_PULSE_CYC = RESET_PULSE_US * CLOCK_HZ / 1000000;
endpackage

// ---- rtl/wdog_tick.sv ----
// one-second and one-minute enable pulses
`timescale 1ns/1ps
module wdog_tick #(
    parameter int SECOND_CYCLES = wdog_pkg::SECOND_CYCLES
) (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic restart,
    output logic      sec_tick,
    output logic      min_tick
);
    logic [24:0] cyc_reg;
    logic [24:0] cyc_next;
    logic [5:0]  sec_reg;
    logic [5:0]  sec_next;
    logic        sec_t_next;
    logic        min_t_next;

    // restart aligns the time base to the reload so a unit is full length
    always_comb
    begin
        cyc_next   = cyc_reg + 25'h0000001;
        sec_next   = sec_reg;
        sec_t_next = 1'b0;
        min_t_next = 1'b0;
        if (restart)
        begin
            cyc_next = 25'h0000000;
            sec_next = 6'h00;
        end
        else if (cyc_reg == 25'(SECOND_CYCLES - 1))
        begin
            cyc_next   = 25'h0000000;
            sec_t_next = 1'b1;
            if (sec_reg == 6'(wdog_pkg::MINUTE_SECONDS - 1))
            begin
                sec_next   = 6'h00;
                min_t_next = 1'b1;
            end
            else
                sec_next = sec_reg + 6'h01;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            cyc_reg  <= 25'h0000000;
            sec_reg  <= 6'h00;
            sec_tick <= 1'b0;
            min_tick <= 1'b0;
        end
        else
        begin
            cyc_reg  <= cyc_next;
            sec_reg  <= sec_next;
            sec_tick <= sec_t_next;
            min_tick <= min_t_next;
        end
    end
endmodule // wdog_tick

// ---- rtl/system_watchdog.sv ----
// super i/o watchdog behind an index/data port pair
// Function
// - expiry without a reload drives a whole-system reset pulse.
// - writing 00 at 30 disables the dog at any time.
// - time base value 00h at F5 makes each count one second.
// - time base value 08h makes each count one minute.
// - count at F6 of 1 to 255 gives that many units, 00h disables.
// - in minutes mode expiry falls exactly M minutes after loading.
// - each write to F6 restarts the countdown from the new value.
`timescale 1ns/1ps
module system_watchdog #(
    parameter int SECOND_CYCLES = wdog_pkg::SECOND_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_addr,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    output logic            system_reset,
    output logic            dog_running
);
    typedef enum logic [2:0] {
        ST_LOCKED = 3'b001,
        ST_HALF   = 3'b010,
        ST_OPEN   = 3'b100
    } lock_t;

    lock_t       lock_reg, lock_next;
    logic [7:0]  index_reg, index_next;
    logic [7:0]  dev_reg, dev_next;
    logic [7:0]  act_reg, act_next;
    logic [7:0]  base_reg, base_next;
    logic [7:0]  count_reg, count_next;
    logic [7:0]  rdata_next;
    logic [11:0] pulse_reg, pulse_next;
    logic        rst_next;
    logic        run_next;
    logic        reload;
    logic        sec_tick;
    logic        min_tick;
    logic        unit_tick;
    logic        cfg_wr;
    logic        cfg_rd;
    logic        dev_ok;

    wire cfg_open = (lock_reg == ST_OPEN);
    assign cfg_wr = cfg_open && io_wr && io_addr == wdog_pkg::DATA_PORT;
    assign cfg_rd = cfg_open && io_rd && io_addr == wdog_pkg::DATA_PORT;
    assign dev_ok = dev_reg == wdog_pkg::WDOG_DEVICE;
    assign reload = cfg_wr && dev_ok &&
                    index_reg == wdog_pkg::OFS_COUNT_VALUE;

    wdog_tick #(
        .SECOND_CYCLES (SECOND_CYCLES)
    ) u_tick (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .restart  (reload),
        .sec_tick (sec_tick),
        .min_tick (min_tick)
    );

    // minute base only for exactly 08h; other values count seconds
    assign unit_tick = (base_reg == wdog_pkg::BASE_MINUTES) ? min_tick
                                                            : sec_tick;

    // unlock sequence and index/data decoding
    always_comb
    begin
        lock_next  = lock_reg;
        index_next = index_reg;
        dev_next   = dev_reg;
        act_next   = act_reg;
        base_next  = base_reg;
        rdata_next = io_rdata;
        if (io_wr && io_addr == wdog_pkg::INDEX_PORT)
        begin
            case (lock_reg)
                ST_LOCKED:
                    lock_next = (io_wdata == wdog_pkg::UNLOCK_VALUE)
                                ? ST_HALF : ST_LOCKED;
                ST_HALF:
                    lock_next = (io_wdata == wdog_pkg::UNLOCK_VALUE)
                                ? ST_OPEN : ST_LOCKED;
                ST_OPEN:
                begin
                    if (io_wdata == wdog_pkg::LOCK_VALUE)
                        lock_next = ST_LOCKED;
                    else
                        index_next = io_wdata;
                end
                default:
                    lock_next = ST_LOCKED;
            endcase
        end
        else if (io_wr && io_addr != wdog_pkg::DATA_PORT)
            lock_next = lock_reg;
        if (cfg_wr)
        begin
            if (index_reg == wdog_pkg::OFS_DEV_SELECT)
                dev_next = io_wdata;
            else if (dev_ok)
            begin
                case (index_reg)
                    wdog_pkg::OFS_ACTIVATE:    act_next   = io_wdata;
                    wdog_pkg::OFS_TIME_BASE:   base_next  = io_wdata;
                    // count writes land in the counter as a reload
                    default:                   act_next   = act_reg;
                endcase
            end
        end
        // unmapped indices read as zero
        if (cfg_rd)
        begin
            case (index_reg)
                wdog_pkg::OFS_DEV_SELECT:  rdata_next = dev_reg;
                wdog_pkg::OFS_ACTIVATE:    rdata_next = dev_ok ? act_reg : 8'h00;
                wdog_pkg::OFS_TIME_BASE:   rdata_next = dev_ok ? base_reg : 8'h00;
                wdog_pkg::OFS_COUNT_VALUE: rdata_next = dev_ok ? count_reg : 8'h00;
                default:                   rdata_next = 8'h00;
            endcase
        end
    end

    // countdown and reset pulse
    always_comb
    begin
        count_next = count_reg;
        pulse_next = pulse_reg;
        run_next   = act_reg[0] && count_reg != 8'h00;
        rst_next   = 1'b0;
        if (reload)
            count_next = io_wdata;
        else if (!act_reg[0])
            count_next = count_reg;
        else if (unit_tick && count_reg != 8'h00)
        begin
            count_next = count_reg - 8'h01;
            if (count_reg == 8'h01)
                pulse_next = 12'(wdog_pkg::RESET_PULSE_CYC);
        end
        if (pulse_reg != 12'h000)
        begin
            if (!(unit_tick && count_reg == 8'h01 && act_reg[0] && !reload))
                pulse_next = pulse_reg - 12'h001;
            rst_next = 1'b1;
        end
    end

    // every output is a flop; reset is synchronous
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            lock_reg     <= ST_LOCKED;
            index_reg    <= 8'h00;
            dev_reg      <= wdog_pkg::RST_DEV_SELECT;
            act_reg      <= wdog_pkg::RST_ACTIVATE;
            base_reg     <= wdog_pkg::RST_TIME_BASE;
            count_reg    <= wdog_pkg::RST_COUNT_VALUE;
            pulse_reg    <= 12'h000;
            io_rdata     <= 8'h00;
            system_reset <= 1'b0;
            dog_running  <= 1'b0;
        end
        else
        begin
            lock_reg     <= lock_next;
            index_reg    <= index_next;
            dev_reg      <= dev_next;
            act_reg      <= act_next;
            base_reg     <= base_next;
            count_reg    <= count_next;
            pulse_reg    <= pulse_next;
            io_rdata     <= rdata_next;
            system_reset <= rst_next;
            dog_running  <= run_next;
        end
    end

    // checks on the counter, the reset pulse and the lock
    a_reload_loads: assert property (@(posedge clock) disable iff (sys_rst)
        reload |=> count_reg == $past(io_wdata))
        else $error("reload did not load count");
    a_expiry_resets: assert property (@(posedge clock) disable iff (sys_rst)
        (act_reg[0] && unit_tick && count_reg == 8'h01 && !reload)
        |=> ##1 system_reset)
        else $error("expiry gave no reset");
    a_idle_no_count: assert property (@(posedge clock) disable iff (sys_rst)
        (!act_reg[0] && !reload) |=> $stable(count_reg))
        else $error("count moved while disabled");
    a_zero_holds: assert property (@(posedge clock) disable iff (sys_rst)
        (count_reg == 8'h00 && !reload) |=> count_reg == 8'h00)
        else $error("zero count moved");
    a_sec_step: assert property (@(posedge clock) disable iff (sys_rst)
        (act_reg[0] && base_reg == wdog_pkg::BASE_SECONDS && !sec_tick
         && !reload) |=> $stable(count_reg))
        else $error("seconds count moved without tick");
    a_min_step: assert property (@(posedge clock) disable iff (sys_rst)
        (act_reg[0] && base_reg == wdog_pkg::BASE_MINUTES && !min_tick
         && !reload) |=> $stable(count_reg))
        else $error("minutes count moved without tick");
    a_min_dec: assert property (@(posedge clock) disable iff (sys_rst)
        (act_reg[0] && base_reg == wdog_pkg::BASE_MINUTES && min_tick
         && !reload && count_reg != 8'h00)
        |=> count_reg == $past(count_reg) - 8'h01)
        else $error("minute tick did not decrement");
    a_unlock_two: assert property (@(posedge clock) disable iff (sys_rst)
        (lock_reg == ST_LOCKED) |=> lock_reg != ST_OPEN)
        else $error("unlocked by one write");
    a_activate_run: assert property (@(posedge clock) disable iff (sys_rst)
        (act_reg[0] && count_reg != 8'h00) |=> dog_running)
        else $error("running flag missing");
    a_data_locked: assert property (@(posedge clock) disable iff (sys_rst)
        (!cfg_open && io_wr) |=> $stable(act_reg))
        else $error("locked write changed register");
endmodule // system_watchdog

// ---- sim/system_watchdog_tb_top.sv ----
// self-checking bench for the configuration-port watchdog
`timescale 1ns/1ps
module system_watchdog_tb_top;
    // short second keeps minute runs cheap
    localparam int SEC = 20;
    localparam int MIN = SEC * wdog_pkg::MINUTE_SECONDS;
    localparam int PULSE = wdog_pkg::RESET_PULSE_CYC;
    logic       clock;
    logic       sys_rst;
    logic       io_wr;
    logic       io_rd;
    logic [7:0] io_addr;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       system_reset;
    logic       dog_running;
    logic [7:0] rdv;
    int         error_cnt;
    int         n_tests;

    system_watchdog #(
        .SECOND_CYCLES(SEC)
    ) DUT (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .io_wr       (io_wr),
        .io_rd       (io_rd),
        .io_addr     (io_addr),
        .io_wdata    (io_wdata),
        .io_rdata    (io_rdata),
        .system_reset(system_reset),
        .dog_running (dog_running)
    );

    // free-running clock
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // strobe held one full cycle so one rising edge takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        io_wr = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(negedge clock);
        io_wr = 1'b0;
    endtask

    task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
        wr(wdog_pkg::INDEX_PORT, idx);
        wr(wdog_pkg::DATA_PORT, d);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        wr(wdog_pkg::INDEX_PORT, idx);
        @(negedge clock);
        io_rd = 1'b1;
        io_addr = wdog_pkg::DATA_PORT;
        @(negedge clock);
        io_rd = 1'b0;
        @(negedge clock);
        d = io_rdata;
    endtask

    task automatic do_reset();
        @(negedge clock);
        sys_rst = 1'b1;
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
    endtask

    task automatic unlock();
        wr(wdog_pkg::INDEX_PORT, wdog_pkg::UNLOCK_VALUE);
        wr(wdog_pkg::INDEX_PORT, wdog_pkg::UNLOCK_VALUE);
    endtask

    task automatic arm(input logic [7:0] base, input logic [7:0] cnt);
        do_reset();
        unlock();
        cfg(wdog_pkg::OFS_DEV_SELECT, wdog_pkg::WDOG_DEVICE);
        cfg(wdog_pkg::OFS_ACTIVATE, 8'h01);
        cfg(wdog_pkg::OFS_TIME_BASE, base);
        cfg(wdog_pkg::OFS_COUNT_VALUE, cnt);
    endtask

    // expiry expected t cycles after the load, then a full pulse
    task automatic expire(input int t);
        int n;
        repeat (t - 3) @(negedge clock);
        check(system_reset === 1'b0, "reset came early");
        for (n = 0; n < 8 && system_reset !== 1'b1; n++)
            @(negedge clock);
        check(system_reset === 1'b1, "no reset on expiry");
        n = 0;
        while (system_reset === 1'b1 && n < PULSE + 100)
        begin
            @(negedge clock);
            n++;
        end
        check(n >= PULSE - 3 && n <= PULSE + 3, "reset pulse width");
    endtask

    task automatic quiet(input int t);
        repeat (t) @(negedge clock);
        check(system_reset === 1'b0, "unexpected reset");
    endtask

    task automatic t_locked();
        do_reset();
        wr(wdog_pkg::INDEX_PORT, wdog_pkg::UNLOCK_VALUE);
        cfg(wdog_pkg::OFS_DEV_SELECT, wdog_pkg::WDOG_DEVICE);
        cfg(wdog_pkg::OFS_ACTIVATE, 8'h01);
        cfg(wdog_pkg::OFS_COUNT_VALUE, 8'h01);
        check(dog_running === 1'b0, "armed while locked");
        quiet(3 * SEC);
        unlock();
        rd(wdog_pkg::OFS_DEV_SELECT, rdv);
        check(rdv === 8'h00, "locked write took effect");
        wr(wdog_pkg::INDEX_PORT, wdog_pkg::LOCK_VALUE);
        cfg(wdog_pkg::OFS_DEV_SELECT, wdog_pkg::WDOG_DEVICE);
        unlock();
        rd(wdog_pkg::OFS_DEV_SELECT, rdv);
        check(rdv === 8'h00, "relocked write took effect");
        $display("test locked done");
    endtask

    task automatic t_seconds();
        arm(wdog_pkg::BASE_SECONDS, 8'h03);
        expire(3 * SEC);
        $display("test seconds done");
    endtask

    task automatic t_minutes();
        arm(wdog_pkg::BASE_MINUTES, 8'h01);
        @(negedge clock);
        check(dog_running === 1'b1, "not running");
        // one cycle spent above, so the wait is one shorter
        expire(MIN - 1);
        $display("test minutes done");
    endtask

    task automatic t_reload();
        arm(wdog_pkg::BASE_SECONDS, 8'h02);
        repeat (SEC * 3 / 2) @(negedge clock);
        cfg(wdog_pkg::OFS_COUNT_VALUE, 8'h02);
        expire(2 * SEC);
        $display("test reload done");
    endtask

    task automatic t_disable();
        arm(wdog_pkg::BASE_SECONDS, 8'h02);
        rd(wdog_pkg::OFS_COUNT_VALUE, rdv);
        check(rdv === 8'h02, "count readback");
        cfg(wdog_pkg::OFS_ACTIVATE, 8'h00);
        @(negedge clock);
        check(dog_running === 1'b0, "still running");
        quiet(4 * SEC);
        cfg(wdog_pkg::OFS_ACTIVATE, 8'h01);
        cfg(wdog_pkg::OFS_COUNT_VALUE, 8'h00);
        @(negedge clock);
        check(dog_running === 1'b0, "zero count runs");
        quiet(4 * SEC);
        cfg(wdog_pkg::OFS_DEV_SELECT, 8'h00);
        rd(wdog_pkg::OFS_ACTIVATE, rdv);
        check(rdv === 8'h00, "other device visible");
        $display("test disable done");
    endtask

    // main sequence, reset held from time zero
    initial
    begin
        error_cnt = 0;
        n_tests = 0;
        sys_rst = 1'b1;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = 8'h00;
        io_wdata = 8'h00;
        t_locked();
        t_seconds();
        t_minutes();
        t_reload();
        t_disable();
        give_verdict();
    end

    // hang guard, well beyond the expected run
    initial
    begin
        #(50 * 30000);
        error_cnt++;
        give_verdict();
    end
endmodule // system_watchdog_tb_top
